// ===== include/abm_pkg.sv
// Package with constants and types for the backplane bus master interface.
package abm_pkg;

	// ----------------------------------------
	// Bus widths
	// ----------------------------------------
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int PAR_LO = 16;
	localparam int PAR_HI = 17;

	// ----------------------------------------
	// Address width selection codes
	// ----------------------------------------
	localparam logic [1:0] AW_16 = 2'h0;
	localparam logic [1:0] AW_18 = 2'h1;
	localparam logic [1:0] AW_22 = 2'h2;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int TIMEOUT_NS = 12_800;
	localparam int TIMEOUT_CYC = (TIMEOUT_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int ADDR_SETUP_NS = 150;
	localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int STROBE_DLY_NS = 100;
	localparam int STROBE_DLY_CYC = (STROBE_DLY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int DESKEW_NS = 200;
	localparam int DESKEW_CYC = (DESKEW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int IDLE_NS = 300;
	localparam int IDLE_CYC = (IDLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int CNT_W = 8;

	// ----------------------------------------
	// Trap vector
	// ----------------------------------------
	localparam logic [7:0] TRAP_VECTOR = 8'h04;

	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	localparam int SYNC_N = 8;
	localparam logic [SYNC_N-1:0] SYNC_RST = 8'hFF;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_STROBE,
		ST_WAIT_REPLY,
		ST_DESKEW,
		ST_WAIT_NEG,
		ST_END
	} abm_state_t;

endpackage

// ===== rtl/abm_master.sv
// Processor-side bus master, arbiter and no-reply timer for the backplane bus.
`timescale 1ns/1ns
// Notes on behaviour
// - Twenty-two multiplexed lines, 4 MB addressing.
// - Address width 16, 18 or 22 bits.
// - Low address and data share 16 lines.
// - Lines 17:16 carry address, then parity.
// - Grant or acknowledge only for pending requests.
// - Exactly one bus master at a time.
// - Each master signal needs slave answer.
// - Abort cycle after 12.8 us without reply.
// - Timeout resumes processor, traps to 4.
// - Bus lines low active except power signals.
// - I/O-page select marks upper 8 KB page.
// - Write control in address phase means write.
module abm_master
	import abm_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_req,
	input wire logic i_req_write,
	input wire logic i_req_byte,
	input wire logic [1:0] i_addr_width,
	input wire logic [ADDR_W-1:0] i_req_addr,
	input wire logic [DATA_W-1:0] i_req_wdata,
	input wire logic i_req_parity_force,
	output logic o_req_busy,
	output logic o_done,
	output logic [DATA_W-1:0] o_rdata,
	output logic o_parity_err,
	output logic o_trap,
	output logic [7:0] o_trap_vector,
	input wire logic [ADDR_W-1:0] i_bus_addr_data_lines_n,
	output logic [ADDR_W-1:0] o_addr_data_drive_n,
	output logic o_addr_data_oe_n,
	output logic o_cycle_sync_strobe_n,
	output logic o_data_input_strobe_n,
	output logic o_data_output_strobe_n,
	output logic o_write_byte_control_n,
	output logic o_io_page_select_n,
	input wire logic i_slave_reply_n,
	input wire logic i_dma_request_n,
	input wire logic i_dma_select_ack_n,
	output logic o_dma_grant_chain_out_n,
	input wire logic i_interrupt_request_n,
	input wire logic i_int_ack_enable,
	output logic o_int_ack_chain_out_n,
	input wire logic i_power_ok,
	input wire logic i_dc_ok,
	output logic o_dma_owns_bus
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [SYNC_N-1:0] sync_in;
	logic [SYNC_N-1:0] sync_out;
	logic reply_s;
	logic dmr_s;
	logic sack_s;
	logic irq_s;
	logic pok_s;
	logic dcok_s;

	assign sync_in = {2'h3, ~i_power_ok, ~i_dc_ok, i_interrupt_request_n,
		i_dma_select_ack_n, i_dma_request_n, i_slave_reply_n};

	abm_sync #(.W(SYNC_N), .RST_VAL(SYNC_RST)) u_sync (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(sync_in),
		.o_sync(sync_out)
	);

	assign reply_s = ~sync_out[0];
	assign dmr_s = ~sync_out[1];
	assign sack_s = ~sync_out[2];
	assign irq_s = ~sync_out[3];
	assign dcok_s = ~sync_out[4];
	assign pok_s = ~sync_out[5];

	logic run_rst;
	assign run_rst = i_sys_rst | ~dcok_s | ~pok_s;

	// ----------------------------------------
	// Cycle state machine
	// ----------------------------------------
	abm_state_t state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic wr_r, wr_nxt;
	logic byte_r, byte_nxt;
	logic dma_r, dma_nxt;
	logic [ADDR_W-1:0] dal_r, dal_nxt;
	logic oe_r, oe_nxt;
	logic sync_r, sync_nxt;
	logic din_r, din_nxt;
	logic dout_r, dout_nxt;
	logic wtbt_r, wtbt_nxt;
	logic bs7_r, bs7_nxt;
	logic done_r, done_nxt;
	logic trap_r, trap_nxt;
	logic perr_r, perr_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic [DATA_W-1:0] wdata_r, wdata_nxt;
	logic pforce_r, pforce_nxt;
	logic iak_r, iak_nxt;
	logic [ADDR_W-1:0] addr_mask;
	logic io_page;

	always_comb begin
		case (i_addr_width)
			AW_16: addr_mask = 22'h00FFFF;
			AW_18: addr_mask = 22'h03FFFF;
			default: addr_mask = 22'h3FFFFF;
		endcase
	end

	// upper 8 KB of the active space
	assign io_page = ((i_req_addr | ~addr_mask) & 22'h3FE000) == 22'h3FE000;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		wr_nxt = wr_r;
		byte_nxt = byte_r;
		dma_nxt = dma_r;
		dal_nxt = dal_r;
		oe_nxt = oe_r;
		sync_nxt = sync_r;
		din_nxt = din_r;
		dout_nxt = dout_r;
		wtbt_nxt = wtbt_r;
		bs7_nxt = bs7_r;
		done_nxt = 1'b0;
		trap_nxt = 1'b0;
		perr_nxt = perr_r;
		rdata_nxt = rdata_r;
		wdata_nxt = wdata_r;
		pforce_nxt = pforce_r;
		iak_nxt = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 1'b1;
				end else if (dma_r) begin
					// DMA master holds bus until it releases both select and request
					if (!sack_s && !dmr_s) begin
						dma_nxt = 1'b0;
					end
				end else if (dmr_s) begin
					// grant only on a pending DMA request
					dma_nxt = 1'b1;
				end else if (irq_s && i_int_ack_enable) begin
					iak_nxt = 1'b1;
				end else if (i_req) begin
					// drive address, masked to the selected width, on shared lines
					dal_nxt = i_req_addr & addr_mask;
					oe_nxt = 1'b1;
					wr_nxt = i_req_write;
					byte_nxt = i_req_byte;
					// write control set in address phase
					wtbt_nxt = i_req_write;
					bs7_nxt = io_page;
					wdata_nxt = i_req_wdata;
					pforce_nxt = i_req_parity_force;
					cnt_nxt = CNT_W'(ADDR_SETUP_CYC - 1);
					state_nxt = ST_ADDR;
				end
			end
			ST_ADDR: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 1'b1;
				end else begin
					sync_nxt = 1'b1;
					bs7_nxt = 1'b0;
					cnt_nxt = CNT_W'(STROBE_DLY_CYC - 1);
					state_nxt = ST_STROBE;
				end
			end
			ST_STROBE: begin
				// data phase reuses the low lines
				if (wr_r) begin
					dal_nxt = {4'h0, 1'b0, pforce_r, wdata_r};
					wtbt_nxt = byte_r;
				end else begin
					oe_nxt = 1'b0;
					wtbt_nxt = 1'b0;
				end
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 1'b1;
				end else begin
					din_nxt = ~wr_r;
					dout_nxt = wr_r;
					cnt_nxt = '0;
					state_nxt = ST_WAIT_REPLY;
				end
			end
			ST_WAIT_REPLY: begin
				if (reply_s) begin
					cnt_nxt = CNT_W'(DESKEW_CYC - 1);
					state_nxt = ST_DESKEW;
				end else if (cnt_r == CNT_W'(TIMEOUT_CYC - 1)) begin
					// resume and trap through vector 4
					trap_nxt = 1'b1;
					din_nxt = 1'b0;
					dout_nxt = 1'b0;
					sync_nxt = 1'b0;
					oe_nxt = 1'b0;
					wtbt_nxt = 1'b0;
					cnt_nxt = CNT_W'(IDLE_CYC);
					state_nxt = ST_IDLE;
				end else begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end
			ST_DESKEW: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 1'b1;
				end else begin
					// data and parity sampled in data phase
					rdata_nxt = ~i_bus_addr_data_lines_n[DATA_W-1:0];
					perr_nxt = ~wr_r & ~i_bus_addr_data_lines_n[PAR_HI];
					din_nxt = 1'b0;
					dout_nxt = 1'b0;
					state_nxt = ST_WAIT_NEG;
				end
			end
			ST_WAIT_NEG: begin
				oe_nxt = 1'b0;
				wtbt_nxt = 1'b0;
				if (!reply_s) begin
					sync_nxt = 1'b0;
					done_nxt = 1'b1;
					cnt_nxt = CNT_W'(IDLE_CYC);
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (run_rst) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			wr_r <= 1'b0;
			byte_r <= 1'b0;
			dma_r <= 1'b0;
			dal_r <= '0;
			oe_r <= 1'b0;
			sync_r <= 1'b0;
			din_r <= 1'b0;
			dout_r <= 1'b0;
			wtbt_r <= 1'b0;
			bs7_r <= 1'b0;
			done_r <= 1'b0;
			trap_r <= 1'b0;
			perr_r <= 1'b0;
			rdata_r <= '0;
			wdata_r <= '0;
			pforce_r <= 1'b0;
			iak_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			wr_r <= wr_nxt;
			byte_r <= byte_nxt;
			dma_r <= dma_nxt;
			dal_r <= dal_nxt;
			oe_r <= oe_nxt;
			sync_r <= sync_nxt;
			din_r <= din_nxt;
			dout_r <= dout_nxt;
			wtbt_r <= wtbt_nxt;
			bs7_r <= bs7_nxt;
			done_r <= done_nxt;
			trap_r <= trap_nxt;
			perr_r <= perr_nxt;
			rdata_r <= rdata_nxt;
			wdata_r <= wdata_nxt;
			pforce_r <= pforce_nxt;
			iak_r <= iak_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// drive asserted levels low
	assign o_addr_data_drive_n = ~dal_r;
	assign o_addr_data_oe_n = ~oe_r;
	assign o_cycle_sync_strobe_n = ~sync_r;
	assign o_data_input_strobe_n = ~din_r;
	assign o_data_output_strobe_n = ~dout_r;
	assign o_write_byte_control_n = ~wtbt_r;
	assign o_io_page_select_n = ~bs7_r;
	assign o_dma_grant_chain_out_n = ~dma_r;
	assign o_int_ack_chain_out_n = ~iak_r;
	assign o_dma_owns_bus = dma_r;
	assign o_req_busy = (state_r != ST_IDLE) | dma_r;
	assign o_done = done_r;
	assign o_rdata = rdata_r;
	assign o_parity_err = perr_r;
	assign o_trap = trap_r;
	assign o_trap_vector = TRAP_VECTOR;
endmodule

// ===== rtl/abm_sync.sv
// Two-flop synchroniser for a group of asynchronous bus inputs.
`timescale 1ns/1ns
module abm_sync
	import abm_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;

	always_comb begin
		meta_nxt = i_async;
		sync_nxt = meta_r;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign o_sync = sync_r;
endmodule

// ===== testbench/abm_master_asserts.sv
// Checker on the bus master ports.
`timescale 1ns/1ns
module abm_master_asserts
	import abm_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic o_trap,
	input wire logic [7:0] o_trap_vector,
	input wire logic o_addr_data_oe_n,
	input wire logic o_cycle_sync_strobe_n,
	input wire logic o_data_input_strobe_n,
	input wire logic o_data_output_strobe_n,
	input wire logic i_dma_request_n,
	input wire logic o_dma_grant_chain_out_n,
	input wire logic o_dma_owns_bus
);
	logic [7:0] stb_r;
	// --------
	// Strobe length counter
	// --------
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || (o_data_input_strobe_n && o_data_output_strobe_n)) begin
			stb_r <= 8'h00;
		end else if (stb_r != 8'hFF) begin
			stb_r <= stb_r + 8'h01;
		end
	end
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);
	// --------
	// Properties
	// --------
	a_trap_vec_fixed: assert property (o_trap |-> o_trap_vector == 8'h04)
		else $error("trap vector");
	a_trap_one_shot: assert property (o_trap |=> !o_trap)
		else $error("trap pulse");
	a_timeout_bound: assert property (stb_r <= 8'h88)
		else $error("strobe too long");
	a_grant_after_req: assert property ($fell(o_dma_grant_chain_out_n) |-> $past(!i_dma_request_n, 2))
		else $error("grant without request");
	a_single_master: assert property (o_dma_owns_bus |-> o_cycle_sync_strobe_n && o_addr_data_oe_n)
		else $error("two masters");
	a_strobe_in_cycle: assert property (!(o_data_input_strobe_n && o_data_output_strobe_n)
		|-> !o_cycle_sync_strobe_n && (o_data_input_strobe_n || o_data_output_strobe_n)) else $error("stray strobe");
	a_read_released: assert property (!o_data_input_strobe_n |-> o_addr_data_oe_n)
		else $error("drive during read");
	a_reset_quiet: assert property (disable iff (1'b0) i_sys_rst |=> o_cycle_sync_strobe_n && o_addr_data_oe_n)
		else $error("bus active in reset");
	c_trap: cover property (o_trap);
	c_read: cover property ($rose(o_data_input_strobe_n));
	c_grant: cover property ($fell(o_dma_grant_chain_out_n));
endmodule

// ===== testbench/abm_master_bench.sv
// Self-checking bench for the backplane bus master.
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
	begin \
		checks_done++; \
		if ((got) !== (ex)) begin \
			error_cnt++; \
			$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
		end \
	end
module abm_master_bench
	import abm_pkg::*;
;
	logic clk, rst = 1'b1, req = 1'b0, wr = 1'b0, dma_n = 1'b1, ack_n = 1'b1;
	logic irq_n = 1'b1, ie = 1'b0, pbad = 1'b0;
	logic byt = 1'b0, pf = 1'b0, dcok = 1'b1;
	logic grant_dn_n;
	logic [1:0] aw = AW_22;
	logic [7:0] dly = 8'h03;
	logic [15:0] wd = 16'h0000;
	logic [21:0] addr = 22'h000000;
	logic busy, done, perr, trap, soe, sync_n, din_n, dout_n, wtb_n, io_n, reply_n, grant_n, iack_n, owns;
	logic [1:0] ctl, wfl;
	logic [7:0] vec;
	logic [15:0] rd;
	logic [21:0] drv_n, lines_n, saddr;
	int error_cnt = 0;
	int checks_done = 0;
	int n;
	abm_master uut (.i_core_clk(clk), .i_sys_rst(rst), .i_req(req), .i_req_write(wr), .i_req_byte(byt),
		.i_addr_width(aw), .i_req_addr(addr), .i_req_wdata(wd), .i_req_parity_force(pf), .o_req_busy(busy),
		.o_done(done), .o_rdata(rd), .o_parity_err(perr), .o_trap(trap), .o_trap_vector(vec),
		.i_bus_addr_data_lines_n(lines_n), .o_addr_data_drive_n(drv_n), .o_addr_data_oe_n(soe),
		.o_cycle_sync_strobe_n(sync_n), .o_data_input_strobe_n(din_n), .o_data_output_strobe_n(dout_n),
		.o_write_byte_control_n(wtb_n), .o_io_page_select_n(io_n), .i_slave_reply_n(reply_n),
		.i_dma_request_n(dma_n), .i_dma_select_ack_n(ack_n), .o_dma_grant_chain_out_n(grant_n),
		.i_interrupt_request_n(irq_n), .i_int_ack_enable(ie), .o_int_ack_chain_out_n(iack_n),
		.i_power_ok(1'b1), .i_dc_ok(dcok), .o_dma_owns_bus(owns));
	abm_slave_model slv (.i_core_clk(clk), .i_delay(dly), .i_parity_bad(pbad), .i_drive_n(drv_n),
		.i_oe_n(soe), .i_sync_n(sync_n), .i_din_n(din_n), .i_dout_n(dout_n), .i_wtb_n(wtb_n), .i_io_n(io_n),
		.o_reply_n(reply_n), .o_lines_n(lines_n), .o_addr(saddr), .o_ctl(ctl), .i_grant_in_n(grant_n),
		.o_grant_out_n(grant_dn_n), .o_wflags(wfl));
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic cyc(input logic w, input logic [1:0] a_w, input logic [21:0] a, input logic [15:0] d);
		tick(4);
		wr = w;
		aw = a_w;
		addr = a;
		wd = d;
		req = 1'b1;
		n = 0;
		while (busy !== 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		req = 1'b0;
		n = 0;
		while (done !== 1'b1 && trap !== 1'b1 && n < 400) begin
			tick(1);
			n++;
		end
		`CHK("cycle end", 1'b1, n < 400)
	endtask
	task automatic t_addr;
		logic [1:0] codes [4] = '{AW_16, AW_18, AW_22, 2'h3};
		logic [21:0] masks [4] = '{22'h00FFFF, 22'h03FFFF, 22'h3FFFFF, 22'h3FFFFF};
		for (int i = 0; i < 4; i++) begin
			cyc(1'b0, codes[i], 22'h3FFFFF, 16'h0000);
			`CHK("address", masks[i], saddr)
			`CHK("read io ctl", 2'b01, ctl)
		end
		$display("address test done");
	endtask
	task automatic t_rw;
		dly = 8'h14;
		cyc(1'b1, AW_22, 22'h000100, 16'hA5C3);
		`CHK("write done", 1'b1, done)
		`CHK("write ctl", 2'b10, ctl)
		`CHK("word flags", 2'b00, wfl)
		byt = 1'b1;
		pf = 1'b1;
		cyc(1'b1, AW_22, 22'h000100, 16'hA5C3);
		`CHK("byte parity flags", 2'b11, wfl)
		byt = 1'b0;
		pf = 1'b0;
		dly = 8'h00;
		cyc(1'b0, AW_22, 22'h000100, 16'h0000);
		`CHK("read data", 16'hA5C3, rd)
		`CHK("parity ok", 1'b0, perr)
		pbad = 1'b1;
		cyc(1'b0, AW_22, 22'h000100, 16'h0000);
		`CHK("parity bad", 1'b1, perr)
		pbad = 1'b0;
		$display("read write test done");
	endtask
	task automatic t_tmo;
		dly = 8'hFF;
		cyc(1'b0, AW_22, 22'h000200, 16'h0000);
		`CHK("trap", 1'b1, trap)
		`CHK("window", 1'b1, n >= 126 && n <= 140)
		`CHK("vector", 8'h04, vec)
		`CHK("no done", 1'b0, done)
		dly = 8'h03;
		cyc(1'b0, AW_22, 22'h000100, 16'h0000);
		`CHK("resumed", 1'b1, done)
		$display("timeout test done");
	endtask
	task automatic t_dma;
		dma_n = 1'b0;
		n = 0;
		while (grant_n !== 1'b0 && n < 20) begin
			tick(1);
			n++;
		end
		`CHK("grant", 1'b0, grant_n)
		ack_n = 1'b0;
		dma_n = 1'b1;
		req = 1'b1;
		tick(6);
		`CHK("dma owner", 1'b1, owns)
		`CHK("cpu quiet", 1'b1, sync_n)
		`CHK("cpu off bus", 1'b1, soe)
		`CHK("grant passed", 1'b0, grant_dn_n)
		req = 1'b0;
		ack_n = 1'b1;
		tick(6);
		`CHK("grant gone", 1'b1, grant_n)
		`CHK("chain released", 1'b1, grant_dn_n)
		$display("dma test done");
	endtask
	task automatic t_irq;
		int acks;
		acks = 0;
		// The request pin is only ever an input of the master.
		irq_n = 1'b0;
		for (int i = 0; i < 20; i++) begin
			tick(1);
			acks += (iack_n === 1'b0);
		end
		`CHK("masked ack", 0, acks)
		ie = 1'b1;
		n = 0;
		while (iack_n !== 1'b0 && n < 20) begin
			tick(1);
			n++;
		end
		`CHK("ack", 1'b0, iack_n)
		irq_n = 1'b1;
		ie = 1'b0;
		$display("interrupt test done");
	endtask
	task automatic t_pwr;
		dly = 8'hFF;
		wr = 1'b0;
		aw = AW_22;
		addr = 22'h000100;
		req = 1'b1;
		n = 0;
		while (din_n !== 1'b0 && n < 50) begin
			tick(1);
			n++;
		end
		req = 1'b0;
		`CHK("strobe seen", 1'b0, din_n)
		dcok = 1'b0;
		tick(4);
		`CHK("reset strobe", 1'b1, din_n)
		`CHK("reset sync", 1'b1, sync_n)
		`CHK("reset drive", 1'b1, soe)
		dcok = 1'b1;
		dly = 8'h03;
		tick(4);
		cyc(1'b0, AW_22, 22'h000100, 16'h0000);
		`CHK("after power", 1'b1, done)
		`CHK("data after power", 16'hA5C3, rd)
		$display("power test done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#1000000;
		error_cnt++;
		results();
	end
	initial begin
		tick(10);
		rst = 1'b0;
		tick(5);
		t_addr();
		t_rw();
		t_tmo();
		t_dma();
		t_irq();
		t_pwr();
		results();
	end
endmodule
bind abm_master abm_master_asserts chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .o_trap(o_trap),
	.o_trap_vector(o_trap_vector), .o_addr_data_oe_n(o_addr_data_oe_n),
	.o_cycle_sync_strobe_n(o_cycle_sync_strobe_n), .o_data_input_strobe_n(o_data_input_strobe_n),
	.o_data_output_strobe_n(o_data_output_strobe_n), .i_dma_request_n(i_dma_request_n),
	.o_dma_grant_chain_out_n(o_dma_grant_chain_out_n), .o_dma_owns_bus(o_dma_owns_bus));

// ===== testbench/abm_slave_model.sv
// Behavioural backplane slave with one memory word and a set reply delay.
`timescale 1ns/1ns
module abm_slave_model (
	input wire logic i_core_clk,
	input wire logic [7:0] i_delay,
	input wire logic i_parity_bad,
	input wire logic [21:0] i_drive_n,
	input wire logic i_oe_n,
	input wire logic i_sync_n,
	input wire logic i_din_n,
	input wire logic i_dout_n,
	input wire logic i_wtb_n,
	input wire logic i_io_n,
	output logic o_reply_n,
	output logic [21:0] o_lines_n,
	output logic [21:0] o_addr,
	output logic [1:0] o_ctl,
	input wire logic i_grant_in_n,
	output logic o_grant_out_n,
	output logic [1:0] o_wflags
);
	logic [15:0] mem = 16'h0000;
	logic [21:0] rd_n = 22'h3FFFFF;
	logic rd_en = 1'b0;
	int cnt = 0;
	initial o_reply_n = 1'b1;
	// Lines are wired low-active and float high when released.
	assign o_lines_n = (i_oe_n ? 22'h3FFFFF : i_drive_n) & (rd_en ? rd_n : 22'h3FFFFF);
	// This device never requests the bus, so it passes the grant on down the chain.
	assign o_grant_out_n = i_grant_in_n;
	always @(posedge i_core_clk) begin
		// Address, page and direction held from the address phase.
		if (i_sync_n && !i_oe_n) begin
			o_addr <= ~o_lines_n;
			o_ctl <= {~i_wtb_n, ~i_io_n};
		end
		if (!i_din_n || !i_dout_n) begin
			// Reply after the set delay; the timeout and power tests set it to 8'hFF, beyond the timeout.
			if (cnt == i_delay) begin
				o_reply_n <= #2 1'b0;
				rd_en <= #2 !i_din_n;
				// Data on the low 16 lines, parity flag on line 17.
				rd_n <= #2 ~{4'h0, i_parity_bad, 1'b0, mem};
				if (!i_dout_n) begin
					mem <= ~o_lines_n[15:0];
					o_wflags <= {~i_wtb_n, ~o_lines_n[16]};
				end
			end else begin
				cnt <= cnt + 1;
			end
		end else begin
			// Reply and data go together once the strobe is gone.
			o_reply_n <= #2 1'b1;
			rd_en <= #2 1'b0;
			cnt <= 0;
		end
	end
endmodule
